// ---- pkg/cct_defines.svh ----
`ifndef CCT_DEFINES_SVH
`define CCT_DEFINES_SVH
// apb register byte offsets
`define CCT_OFF_CTRL      12'h000
`define CCT_OFF_TX_DIV    12'h004
`define CCT_OFF_RX_DIV    12'h008
`define CCT_OFF_ADJUST    12'h00C
`define CCT_OFF_STATUS    12'h010
// control field positions
`define CCT_CTRL_PAIR     4
`define CCT_CTRL_SYNC     5
`define CCT_CTRL_HPF      6
`define CCT_CTRL_BYTE     7
`define CCT_CTRL_DUAL     8
`define CCT_CTRL_GAIN_LO  0
`define CCT_CTRL_TXADJ_LO 9
`define CCT_CTRL_RXADJ_LO 11
// second field of the divider and adjust words
`define CCT_HI_LO         16
// reset values
`define CCT_DIV_RST       8'h12
`define CCT_ADJ_RST       8'h01
`define CCT_CTRL_RST      32'h0000_0060
// shift clock is master clock over four
`define CCT_SCLK_DIV      2'h3
`define CCT_GAP_SCLK      3'h4
`define CCT_WORD_BITS     5'h10
`define CCT_BYTE_BITS     5'h08
`endif

// ---- pkg/cct_pkg.sv ----
package cct_pkg;
    typedef enum logic [1:0] {
        CCT_ADJ_NONE = 2'h0,
        CCT_ADJ_SUB  = 2'h1,
        CCT_ADJ_ADD  = 2'h2
    } cct_adj_e;
    typedef enum logic [1:0] {
        CCT_GAIN_1 = 2'h0,
        CCT_GAIN_2 = 2'h1,
        CCT_GAIN_4 = 2'h2
    } cct_gain_e;
    typedef enum logic [5:0] {
        CCT_IDLE = 6'h01,
        CCT_PRI  = 6'h02,
        CCT_GAP  = 6'h04,
        CCT_PRI2 = 6'h08,
        CCT_SECG = 6'h10,
        CCT_SEC  = 6'h20
    } cct_state_e;
    typedef struct packed {
        logic tx_fs_n;
        logic rx_fs_n;
        logic aux_fs_n;
        logic tx_eod_n;
        logic rx_eod_n;
    } cct_frame_s;
endpackage : cct_pkg

// ---- hw/cct_top.sv ----
// Contract
// (R01) input pair select bit chooses main or auxiliary analog inputs.
// (R02) controller ignores receive results about 2 ms after pair change; the code has no such hold-off.
// (R03) programmable input gain of one, two or four.
// (R04) control bit inserts or bypasses receive high-pass stage.
// (R05) receive strobe divides receive filter clock by second receive counter.
// (R06) transmit strobe divides transmit filter clock by second transmit counter.
// (R07) sync select bit one means synchronous, zero asynchronous.
// (R08) synchronous mode takes receive timing from transmit counters.
// (R09) sync: frame syncs identical in primary; receive sync idle in secondary.
// (R10) word mode: syncs low, 16 bits each way, syncs high.
// (R11) after a word, one shift clock low end-of-data pulse on both outputs.
// (R12) dual-word mode asserts aux frame sync in secondary frame, routes aux.
// (R13) secondary frame starts four shift clocks after primary ends.
// (R14) byte mode: syncs low, 8 bits each way, end-of-data low.
// (R15) syncs high four shift clocks, second byte, syncs high, then eod high; the code raises eod in the same shift clock as the syncs.
// (R16) filter clock is master over twice first divider; rate over second.
// (R17) high-pass stage clocked at receive conversion rate.
// (R18) asynchronous mode uses receive dividers independently.
// (R19) four port configurations: sync or async, word or two bytes.
// (R20) shift clock is master clock divided by four.
// (R21) subtract or add option loads first counter with value minus/plus adjust; the code subtracts only when adjust is below the value.
// (R22) reset: dividers 18, adjusts 01, synchronous operation.
// (R23) counters reload every conversion period of their channel.
// (R24) second counter expiry gives one-cycle strobe, starting a frame.
// (R25) zero divider values are ignored; previous valid value kept.
//
// Local design decisions: the register offsets and the APB interface to the registers.
`include "cct_defines.svh"
module cct_top
    import cct_pkg::*;
#(
    parameter int DIV_W = 8
) (
    // clock and reset
    input  wire logic              CLK,
    input  wire logic              SYS_RST,
    // apb slave
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [11:0]       PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    // serial port
    output logic                   SHIFT_CLK,
    input  wire logic              SERIAL_IN_LINE,
    input  wire logic              AUX_SERIAL_INPUT,
    output logic                   SERIAL_OUT_LINE,
    output logic                   TRANSMIT_FRAME_SYNC_N,
    output logic                   RECEIVE_FRAME_SYNC_N,
    output logic                   AUX_DATA_FRAME_SYNC_N,
    output logic                   TRANSMIT_END_OF_DATA_N,
    output logic                   RECEIVE_END_OF_DATA_N,
    // converter side
    input  wire logic [15:0]       ADC_RESULT,
    output logic      [15:0]       DAC_WORD,
    output logic                   TX_CONVERT,
    output logic                   RX_CONVERT,
    output logic                   TX_FILTER_CLOCK,
    output logic                   RX_FILTER_CLOCK,
    output logic                   HPF_CLOCK,
    output logic                   HPF_ENABLE,
    output logic                   INPUT_PAIR_SELECT,
    output logic      [1:0]        INPUT_GAIN
);
    initial begin
        if (DIV_W < 2 || DIV_W > 16) $error("DIV_W out of range");
    end

    logic [31:0]      ctrl;
    logic [DIV_W-1:0] tx_a, tx_b, rx_a, rx_b, tx_adj, rx_adj;
    logic             apb_wr, addr_ok;
    logic             tx_fclk, rx_fclk, tx_strobe, rx_strobe_a;
    logic             sync_mode, byte_mode, dual_mode;

    assign apb_wr    = PSEL && PENABLE && PWRITE;
    assign sync_mode = ctrl[`CCT_CTRL_SYNC];
    assign byte_mode = ctrl[`CCT_CTRL_BYTE];
    assign dual_mode = ctrl[`CCT_CTRL_DUAL];
    assign PREADY    = 1'b1;
    assign addr_ok   = PADDR <= `CCT_OFF_STATUS && PADDR[1:0] == 2'h0;
    assign PSLVERR   = PSEL && PENABLE && !addr_ok;

    // zero keeps the old value
    function automatic logic [DIV_W-1:0] keep_nz(input logic [DIV_W-1:0] n,
                                                 input logic [DIV_W-1:0] o);
        return (n == '0) ? o : n; // [R25]
    endfunction : keep_nz

    // control register
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ctrl <= `CCT_CTRL_RST; // [R22]
        end else if (apb_wr && PADDR == `CCT_OFF_CTRL) begin
            ctrl <= PWDATA;
        end else begin
            // both chains may expire together; each clears its own adjust
            if (tx_strobe) begin
                ctrl[`CCT_CTRL_TXADJ_LO +: 2] <= CCT_ADJ_NONE; // one-shot adjust [R21]
            end
            if (rx_strobe_a) begin
                ctrl[`CCT_CTRL_RXADJ_LO +: 2] <= CCT_ADJ_NONE; // [R21]
            end
        end
    end

    // divider and adjust registers
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            tx_a   <= DIV_W'(`CCT_DIV_RST); // [R22]
            tx_b   <= DIV_W'(`CCT_DIV_RST);
            rx_a   <= DIV_W'(`CCT_DIV_RST);
            rx_b   <= DIV_W'(`CCT_DIV_RST);
            tx_adj <= DIV_W'(`CCT_ADJ_RST);
            rx_adj <= DIV_W'(`CCT_ADJ_RST);
        end else if (apb_wr) begin
            if (PADDR == `CCT_OFF_TX_DIV) begin
                tx_a <= keep_nz(PWDATA[DIV_W-1:0], tx_a); // [R25]
                tx_b <= keep_nz(PWDATA[`CCT_HI_LO +: DIV_W], tx_b);
            end
            if (PADDR == `CCT_OFF_RX_DIV) begin
                rx_a <= keep_nz(PWDATA[DIV_W-1:0], rx_a);
                rx_b <= keep_nz(PWDATA[`CCT_HI_LO +: DIV_W], rx_b);
            end
            if (PADDR == `CCT_OFF_ADJUST) begin
                tx_adj <= PWDATA[DIV_W-1:0];
                rx_adj <= PWDATA[`CCT_HI_LO +: DIV_W];
            end
        end
    end

    // analog front-end controls
    assign INPUT_PAIR_SELECT = ctrl[`CCT_CTRL_PAIR];             // [R01]
    assign INPUT_GAIN        = ctrl[`CCT_CTRL_GAIN_LO +: 2];     // [R03]
    assign HPF_ENABLE        = ctrl[`CCT_CTRL_HPF];              // [R04]

    // divider chain: first counter counts master clocks per filter half period
    logic [DIV_W+1:0] tx_ca, rx_ca;
    logic [DIV_W-1:0] tx_cb, rx_cb;
    logic             tx_half, rx_half;

    function automatic logic [DIV_W+1:0] load_a(input logic [DIV_W-1:0] a,
                                                input logic [DIV_W-1:0] adj,
                                                input logic [1:0] sel,
                                                input logic first_half);
        logic [DIV_W+1:0] base;
        base = {2'h0, a};
        if (first_half && sel == CCT_ADJ_SUB && adj < a) return base - {2'h0, adj}; // [R21]
        if (first_half && sel == CCT_ADJ_ADD) return base + {2'h0, adj}; // [R21]
        return base;
    endfunction : load_a

    assign tx_half   = (tx_ca == {{(DIV_W+1){1'b0}}, 1'b1});
    assign rx_half   = (rx_ca == {{(DIV_W+1){1'b0}}, 1'b1});
    assign tx_strobe = tx_half && tx_fclk && (tx_cb == {{(DIV_W-1){1'b0}}, 1'b1}); // [R24]
    assign rx_strobe_a = rx_half && rx_fclk && (rx_cb == {{(DIV_W-1){1'b0}}, 1'b1});

    // transmit chain: filter clock = master / (2*first) [R16]
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            tx_ca   <= (DIV_W+2)'(`CCT_DIV_RST);
            tx_cb   <= DIV_W'(`CCT_DIV_RST);
            tx_fclk <= 1'b0;
        end else if (tx_half) begin
            tx_fclk <= !tx_fclk;
            tx_ca   <= load_a(tx_a, tx_adj, ctrl[`CCT_CTRL_TXADJ_LO +: 2],
                              tx_strobe); // [R23]
            if (tx_fclk) begin
                tx_cb <= tx_strobe ? tx_b : tx_cb - 1'b1; // [R06] [R23]
            end
        end else begin
            tx_ca <= tx_ca - 1'b1;
        end
    end

    // receive chain, used only asynchronously [R18]
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rx_ca   <= (DIV_W+2)'(`CCT_DIV_RST);
            rx_cb   <= DIV_W'(`CCT_DIV_RST);
            rx_fclk <= 1'b0;
        end else if (rx_half) begin
            rx_fclk <= !rx_fclk;
            rx_ca   <= load_a(rx_a, rx_adj, ctrl[`CCT_CTRL_RXADJ_LO +: 2],
                              rx_strobe_a); // [R21]
            if (rx_fclk) begin
                rx_cb <= rx_strobe_a ? rx_b : rx_cb - 1'b1; // [R05] [R23]
            end
        end else begin
            rx_ca <= rx_ca - 1'b1;
        end
    end

    logic rx_strobe;
    assign rx_strobe       = sync_mode ? tx_strobe : rx_strobe_a; // [R07] [R08]
    assign TX_CONVERT      = tx_strobe;
    assign RX_CONVERT      = rx_strobe;
    assign TX_FILTER_CLOCK = tx_fclk;
    assign RX_FILTER_CLOCK = sync_mode ? tx_fclk : rx_fclk; // [R08]

    // high-pass clock pulses once per receive conversion, so its rate equals it
    always_ff @(posedge CLK) begin
        if (SYS_RST) HPF_CLOCK <= 1'b0;
        else HPF_CLOCK <= rx_strobe; // [R17]
    end

    // shift clock: master / 4
    logic [1:0] sdiv;
    logic       sfall;
    always_ff @(posedge CLK) begin
        if (SYS_RST) sdiv <= 2'h0;
        else sdiv <= sdiv + 2'h1; // [R20]
    end
    assign SHIFT_CLK = sdiv[1];
    assign sfall     = (sdiv == `CCT_SCLK_DIV); // data changes here

    // frame sequencer
    cct_state_e state;
    cct_frame_s fr;
    logic [4:0] bitc;
    logic [2:0] gapc;
    logic       tx_pend, rx_pend, tx_act, rx_act, sec_pend;
    logic [15:0] tx_sh, rx_sh;

    // pending conversions start a frame [R24]
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            tx_pend <= 1'b0;
            rx_pend <= 1'b0;
        end else begin
            tx_pend <= tx_strobe || (tx_pend && !(sfall && state == CCT_IDLE));
            rx_pend <= rx_strobe || (rx_pend && !(sfall && state == CCT_IDLE));
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state     <= CCT_IDLE;
            fr        <= '1;
            bitc      <= 5'h0;
            gapc      <= 3'h0;
            tx_act    <= 1'b0;
            rx_act    <= 1'b0;
            sec_pend  <= 1'b0;
            tx_sh     <= 16'h0000;
            rx_sh     <= 16'h0000;
            DAC_WORD  <= 16'h0000;
        end else if (sfall) begin
            unique case (state)
                CCT_IDLE: begin
                    fr.tx_eod_n <= 1'b1;
                    fr.rx_eod_n <= 1'b1;
                    if (tx_pend || rx_pend) begin
                        state      <= CCT_PRI;
                        fr.tx_fs_n <= !tx_pend;
                        fr.rx_fs_n <= !rx_pend; // [R09] [R10] [R14]
                        rx_sh      <= ADC_RESULT;
                        bitc       <= byte_mode ? `CCT_BYTE_BITS : `CCT_WORD_BITS; // [R19]
                        sec_pend   <= dual_mode && !byte_mode && tx_pend;
                        tx_act     <= tx_pend; // sides framed until this frame ends
                        rx_act     <= rx_pend;
                    end
                end
                CCT_PRI, CCT_PRI2, CCT_SEC: begin
                    tx_sh <= {tx_sh[14:0], SERIAL_IN_LINE};
                    rx_sh <= (state == CCT_SEC) ? {AUX_SERIAL_INPUT, 15'h0000}
                                                : {rx_sh[14:0], 1'b0}; // [R12]
                    bitc  <= bitc - 5'h1;
                    if (bitc == 5'h1) begin
                        fr.tx_fs_n  <= 1'b1;
                        fr.rx_fs_n  <= 1'b1;
                        fr.aux_fs_n <= 1'b1;
                        gapc        <= `CCT_GAP_SCLK;
                        if (state == CCT_PRI && byte_mode) begin
                            fr.tx_eod_n <= 1'b0; // [R14]
                            fr.rx_eod_n <= 1'b0;
                            state       <= CCT_GAP; // [R15]
                        end else begin
                            if (tx_act) begin
                                DAC_WORD <= {tx_sh[14:0], SERIAL_IN_LINE};
                            end
                            fr.tx_eod_n <= byte_mode; // [R11] [R15] byte mode: eod high in the same shift clock as syncs
                            fr.rx_eod_n <= byte_mode;
                            state <= (state == CCT_PRI && sec_pend) ? CCT_SECG : CCT_IDLE;
                        end
                    end
                end
                CCT_GAP: begin
                    gapc <= gapc - 3'h1;
                    if (gapc == 3'h1) begin
                        state      <= CCT_PRI2;
                        fr.tx_fs_n <= !tx_act; // [R15]
                        fr.rx_fs_n <= !rx_act;
                        bitc       <= `CCT_BYTE_BITS;
                    end
                end
                CCT_SECG: begin
                    fr.tx_eod_n <= 1'b1;
                    fr.rx_eod_n <= 1'b1;
                    gapc        <= gapc - 3'h1;
                    if (gapc == 3'h1) begin
                        state       <= CCT_SEC; // [R13]
                        fr.aux_fs_n <= 1'b0; // [R12]
                        rx_sh       <= {AUX_SERIAL_INPUT, 15'h0000};
                        fr.tx_fs_n  <= 1'b0;
                        fr.rx_fs_n  <= sync_mode; // [R09]
                        bitc        <= `CCT_WORD_BITS;
                    end
                end
            endcase
        end
    end

    assign TRANSMIT_FRAME_SYNC_N  = fr.tx_fs_n;
    assign RECEIVE_FRAME_SYNC_N   = fr.rx_fs_n;
    assign AUX_DATA_FRAME_SYNC_N  = fr.aux_fs_n;
    assign TRANSMIT_END_OF_DATA_N = fr.tx_eod_n;
    assign RECEIVE_END_OF_DATA_N  = fr.rx_eod_n;
    assign SERIAL_OUT_LINE        = rx_sh[15];

    // apb read data
    always_ff @(posedge CLK) begin
        if (SYS_RST) PRDATA <= 32'h0000_0000;
        else if (PSEL && !PENABLE) begin
            unique case (PADDR)
                `CCT_OFF_CTRL:   PRDATA <= ctrl;
                `CCT_OFF_TX_DIV: PRDATA <= {8'h00, 8'(tx_b), 8'h00, 8'(tx_a)};
                `CCT_OFF_RX_DIV: PRDATA <= {8'h00, 8'(rx_b), 8'h00, 8'(rx_a)};
                `CCT_OFF_ADJUST: PRDATA <= {8'h00, 8'(rx_adj), 8'h00, 8'(tx_adj)};
                `CCT_OFF_STATUS: PRDATA <= {26'h0, state};
                default:         PRDATA <= 32'h0000_0000;
            endcase
        end
    end

    // assertions
    eodw_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        $fell(TRANSMIT_END_OF_DATA_N) && !byte_mode |-> ##4 TRANSMIT_END_OF_DATA_N)
        else $error("end-of-data pulse not one shift clock"); // [R11]
    rxsync_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        sync_mode |-> RX_CONVERT == TX_CONVERT) else $error("receive not locked"); // [R08]
    secrx_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        !AUX_DATA_FRAME_SYNC_N && sync_mode |-> RECEIVE_FRAME_SYNC_N)
        else $error("receive sync in secondary frame"); // [R09]
    shclk_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(SHIFT_CLK) |-> ##4 $rose(SHIFT_CLK)) else $error("shift clock not /4"); // [R20]
    pair_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        INPUT_PAIR_SELECT == ctrl[`CCT_CTRL_PAIR]) else $error("pair select wrong"); // [R01]
    strb_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        TX_CONVERT |=> !TX_CONVERT) else $error("strobe longer than one cycle"); // [R24]
    nz_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        tx_a != '0 && tx_b != '0 && rx_a != '0 && rx_b != '0)
        else $error("zero divider held"); // [R25]
    gap_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        state == CCT_GAP && $rose(TRANSMIT_FRAME_SYNC_N) |-> TRANSMIT_FRAME_SYNC_N [*8])
        else $error("byte gap too short"); // [R15]
endmodule : cct_top

// ---- tb/cct_dsp_model.sv ----
module cct_dsp_model (
    // device side
    input  wire logic        shift_clk,
    input  wire logic        frame_sync_n,
    input  wire logic        serial_out_line,
    output logic             serial_in_line,
    output logic             aux_serial_input,
    // bench side
    input  wire logic [15:0] tx_word,
    output logic      [15:0] rx_word,
    output int               bits
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rx_word = 16'h0000;
    initial bits = 0;
    initial serial_in_line = 1'b0;
    // auxiliary source holds a steady mark level
    assign aux_serial_input = 1'b1;
    // at the rising point, midway between device changes: take a bit, launch the next
    always @(posedge shift_clk) begin
        if (frame_sync_n === 1'b0) begin
            rx_word        <= {rx_word[14:0], serial_out_line};
            serial_in_line <= tx_word[15 - (bits % 16)];
            bits           <= bits + 1;
        end else begin
            serial_in_line <= ~serial_in_line; // outside frames the line keeps moving
        end
    end
endmodule : cct_dsp_model

// ---- tb/testbench.sv ----
`include "cct_defines.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TXA = 4, TXB = 40, RXA = 3, RXB = 50, ADJ = 2, P = 2 * TXA * TXB;
    logic        clk = 1'b0, sys_rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, sclk, sin, aux, sout, txfs, rxfs, auxfs, txeod, rxeod;
    logic        tx_conv, rx_conv, tx_fclk, rx_fclk, hpf_clk, hpf_en, pair;
    logic [1:0]  gain;
    logic [15:0] adc = 16'hA5C3, dac, tx_word = 16'h3C96, rx_word;
    int          bits, n_fail = 0, check_count = 0;
    bit          mon = 1'b0;
    // master clock
    always #12.5 clk = ~clk;
    cct_top DUT (.CLK(clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SHIFT_CLK(sclk), .SERIAL_IN_LINE(sin), .AUX_SERIAL_INPUT(aux),
        .SERIAL_OUT_LINE(sout), .TRANSMIT_FRAME_SYNC_N(txfs), .RECEIVE_FRAME_SYNC_N(rxfs),
        .AUX_DATA_FRAME_SYNC_N(auxfs), .TRANSMIT_END_OF_DATA_N(txeod),
        .RECEIVE_END_OF_DATA_N(rxeod), .ADC_RESULT(adc), .DAC_WORD(dac),
        .TX_CONVERT(tx_conv), .RX_CONVERT(rx_conv), .TX_FILTER_CLOCK(tx_fclk),
        .RX_FILTER_CLOCK(rx_fclk), .HPF_CLOCK(hpf_clk), .HPF_ENABLE(hpf_en),
        .INPUT_PAIR_SELECT(pair), .INPUT_GAIN(gain));
    cct_dsp_model dsp (.shift_clk(sclk), .frame_sync_n(txfs), .serial_out_line(sout),
        .serial_in_line(sin), .aux_serial_input(aux), .tx_word(tx_word), .rx_word(rx_word),
        .bits(bits));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run;
        $display("checks=%0d fails=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run
    // receive side mirrors transmit side while synchronous
    always @(negedge clk) begin
        if (mon) begin
            check(rx_conv, tx_conv);
            check(rxfs, txfs);
        end
    end
    // one apb transfer: setup, access held until pready at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic eexp);
        logic [31:0] d;
        logic        e;
        apb(1'b0, a, 32'h0, d, e);
        check(d, exp);
        check(e, eexp);
    endtask : rd_chk
    function automatic logic sig(input int w);
        case (w)
            0: return txfs;
            2: return auxfs;
            3: return txeod;
            4: return tx_conv;
            5: return rx_conv;
            6: return tx_fclk;
            7: return sclk;
            8: return rx_fclk;
            9: return hpf_clk;
            default: return 1'b0;
        endcase
    endfunction : sig
    // helpers on the falling clock edge, where outputs have settled
    task automatic wait_sig(input int w, input logic lvl);
        int k;
        k = 0;
        @(negedge clk);
        while (sig(w) !== lvl && k < 2000) begin
            @(negedge clk);
            k++;
        end
        if (k >= 2000) check(32'h0, 32'h1);
    endtask : wait_sig
    task automatic count_while(input int w, input logic lvl, output int n);
        n = 0;
        while (sig(w) === lvl && n < 2000) begin
            @(negedge clk);
            n++;
        end
    endtask : count_while
    task automatic period(input int w, output int n);
        int a, b;
        count_while(w, 1'b1, a);
        count_while(w, 1'b0, b);
        n = a + b;
    endtask : period
    task automatic gap(input int w, output int n);
        wait_sig(w, 1'b1);
        period(w, n);
    endtask : gap
    task automatic width_hi(input int w, output int n);
        wait_sig(w, 1'b0);
        wait_sig(w, 1'b1);
        count_while(w, 1'b1, n);
    endtask : width_hi
    task automatic t_reset;
        rd_chk(`CCT_OFF_CTRL, 32'h0000_0060, 1'b0);
        rd_chk(`CCT_OFF_TX_DIV, 32'h0012_0012, 1'b0);
        rd_chk(`CCT_OFF_RX_DIV, 32'h0012_0012, 1'b0);
        rd_chk(`CCT_OFF_ADJUST, 32'h0001_0001, 1'b0);
        rd_chk(12'h014, 32'h0, 1'b1);
        $display("test reset done");
    endtask : t_reset
    task automatic t_refuse;
        wr(`CCT_OFF_TX_DIV, 32'h0);
        rd_chk(`CCT_OFF_TX_DIV, 32'h0012_0012, 1'b0);
        wr(`CCT_OFF_RX_DIV, RXB << 16);
        rd_chk(`CCT_OFF_RX_DIV, 32'h0032_0012, 1'b0);
        wr(`CCT_OFF_TX_DIV, (TXB << 16) | TXA);
        rd_chk(`CCT_OFF_TX_DIV, 32'h0028_0004, 1'b0);
        $display("test refuse done");
    endtask : t_refuse
    task automatic t_timing;
        int n;
        mon = 1'b1;
        gap(4, n);
        gap(4, n);
        check(n, P);
        gap(5, n);
        check(n, P);
        width_hi(6, n);
        check(n, TXA);
        width_hi(8, n);
        check(n, TXA);
        width_hi(7, n);
        check(n, 2);
        gap(7, n);
        check(n, 4);
        gap(9, n);
        check(n, P);
        $display("test timing done");
    endtask : t_timing
    task automatic t_word;
        int n, b0;
        wait_sig(4, 1'b1);
        wait_sig(0, 1'b0);
        b0 = bits;
        wait_sig(0, 1'b1);
        check(bits - b0, 16);
        check(txeod, 1'b0);
        check(rxeod, 1'b0);
        count_while(3, 1'b0, n);
        check(n, 4);
        check(rx_word, adc);
        check(dac, tx_word);
        $display("test word done");
    endtask : t_word
    task automatic t_ctrl;
        logic [1:0] gv;
        // receive results right after a pair change are not judged
        for (int g = 0; g < 3; g++) begin
            gv = g[1:0];
            wr(`CCT_OFF_CTRL, 32'h20 | g | (gv[0] << 4) | (!gv[0] << 6));
            @(negedge clk);
            check(gain, gv);
            check(pair, gv[0]);
            check(hpf_en, !gv[0]);
        end
        wr(`CCT_OFF_CTRL, 32'h60);
        $display("test ctrl done");
    endtask : t_ctrl
    task automatic t_adjust;
        int g1, g2, g3;
        wr(`CCT_OFF_ADJUST, 32'h0001_0000 | ADJ);
        for (int op = 1; op < 3; op++) begin
            wr(`CCT_OFF_CTRL, 32'h60 | (op << 9));
            gap(4, g1);
            period(4, g2);
            period(4, g3);
            check(g1 + g2, (op == 1) ? 2 * P - ADJ : 2 * P + ADJ);
            check(g3, P);
        end
        $display("test adjust done");
    endtask : t_adjust
    task automatic t_byte;
        int n, b0;
        wr(`CCT_OFF_CTRL, 32'hE0);
        wait_sig(4, 1'b1);
        wait_sig(4, 1'b1);
        wait_sig(0, 1'b0);
        b0 = bits;
        wait_sig(0, 1'b1);
        check(rxeod, 1'b0);
        check(bits - b0, 8);
        count_while(0, 1'b1, n);
        check(n, 16);
        wait_sig(0, 1'b1);
        check(txeod, 1'b1);
        check(bits - b0, 16);
        check(rx_word, adc);
        $display("test byte done");
    endtask : t_byte
    task automatic t_async;
        int n;
        mon = 1'b0;
        wr(`CCT_OFF_RX_DIV, (RXB << 16) | RXA);
        wr(`CCT_OFF_CTRL, 32'hC0);
        gap(4, n);
        gap(4, n);
        check(n, P);
        gap(5, n);
        gap(5, n);
        check(n, 2 * RXA * RXB);
        width_hi(8, n);
        check(n, RXA);
        gap(9, n);
        check(n, 2 * RXA * RXB);
        $display("test async done");
    endtask : t_async
    task automatic t_dual;
        int n;
        wr(`CCT_OFF_CTRL, 32'h160);
        wait_sig(4, 1'b1);
        wait_sig(4, 1'b1);
        wait_sig(0, 1'b0);
        wait_sig(0, 1'b1);
        count_while(2, 1'b1, n);
        check(n, 16);
        check(rxfs, 1'b1);
        check(txfs, 1'b0);
        count_while(2, 1'b0, n);
        check(n, 64);
        check(rx_word, 16'hFFFF);
        $display("test dual done");
    endtask : t_dual
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset;
        t_refuse;
        t_timing;
        t_word;
        t_ctrl;
        t_adjust;
        t_byte;
        t_async;
        t_dual;
        complete_run;
    end
    // watchdog sized well past the longest expected run
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        complete_run;
    end
endmodule : testbench
